// ==== inc/lhm_defines.svh ====
// offsets, field positions, reset values and timing counts for lhm
`ifndef LHM_DEFINES_SVH
`define LHM_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define LHM_OFF_STATUS 8'h00
`define LHM_OFF_MODE 8'h04
`define LHM_OFF_CC_TWO 8'h08
`define LHM_OFF_CC_FIVE 8'h14

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define LHM_CC2_RX_EDGE 0
`define LHM_CC2_TX_EDGE 1
`define LHM_CC2_TX_ZS 2
`define LHM_CC2_RX_ZS 3
`define LHM_CC2_W 4
`define LHM_CC5_RATE_LO 6
`define LHM_CC5_RATE_HI 7
`define LHM_MODE_SW 0

// ----------------------------------------------------------------------
// reset values: every control bit clears to zero
// ----------------------------------------------------------------------
`define LHM_CC2_RST 4'h0
`define LHM_RATE_RST 2'h0

// ----------------------------------------------------------------------
// timing: clock and backplane rates in kHz, phase accumulator width
// ----------------------------------------------------------------------
`define LHM_MCLK_KHZ 40000
`define LHM_BP_KHZ_16M 16384
`define LHM_BP_KHZ_8M 8192
`define LHM_BP_KHZ_4M 4096
`define LHM_BP_KHZ_2M 2048
`define LHM_PHASE_W 16

`endif

// ==== inc/lhm_pkg.sv ====
// types shared by the lhm pin decode block
package lhm_pkg;

  // backplane clock rate code, zero is the fastest
  typedef enum logic [1:0] {
    LHM_BP_16M = 2'h0,
    LHM_BP_8M = 2'h1,
    LHM_BP_4M = 2'h3,
    LHM_BP_2M = 2'h2
  } lhm_bp_rate_t;

  // registered state of the decode block, apart from the pin synchroniser flops in lhm_sync
  typedef struct packed {
    logic [3:0] ccTwo;
    lhm_bp_rate_t bpRate;
    logic swMode;
    logic rxClkPrev;
    logic txClkPrev;
    logic rxPos;
    logic rxNeg;
    logic txPos;
    logic txNeg;
    logic [15:0] bpPhase;
    logic backplane_clock_out;
    logic jaEnable;
    logic jaPlaceTx;
    logic jaClkPll;
    logic lineT1;
    logic eqLimit;
    logic [2:0] waveshape;
    logic [1:0] loopback;
    logic ack;
    logic [31:0] rdData;
  } lhm_state_t;

endpackage

// ==== rtl/lhm_pin_decode.sv ====
// hardware mode strap decode, rail timing and wishbone control registers
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "lhm_defines.svh"

// Summary of operation
// R1 - edge select low: rx rails change on rx clock rise, tx sampled on fall
// R2 - edge select high: rx rails change on rx clock fall, tx on rise
// R3 - edge select pin drives both tx and rx edge bits, bits 1 and 0
// R4 - jitter attenuator disable pin low keeps it on, high turns it off
// R5 - line standard pin low selects E1, high selects T1
// R6 - zero substitution pin low enables HDB3 or B8ZS, high disables both
// R7 - zero substitution pin drives rx and tx coding bits, bits 3 and 2
// R8 - hardware reset low clears every control bit to zero
// R9 - jitter clock mux low takes attenuator clock straight from master clock
// R10 - jitter clock mux high takes attenuator clock from internal PLL
// R11 - placement pin low puts attenuator in rx path, high in tx path
// R12 - backplane clock follows recovered rx clock, rate from bits 7 and 6
// R13 - hardware mode forces the fastest backplane rate, 16.384 MHz
// R14 - equalizer gain limit pin sets rx equalizer sensitivity range
// R15 - waveshape pins select transmit pulse shape in hardware mode
// R16 - two loopback pins select the loopback in hardware mode
// R17 - all straps pass a two-flop synchroniser before any use
module lhm_pin_decode (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic hw_reset_n,
  input wire logic rxTxEdgeSelect,
  input wire logic jitterAttenDisable,
  input wire logic lineStandardSelect,
  input wire logic zeroSubstEnablePin,
  input wire logic jitterClockMuxSelect,
  input wire logic jitterAttenPlacement,
  input wire logic equalizerGainLimit,
  input wire logic [2:0] txWaveshapeSelect,
  input wire logic [1:0] loopbackSelect,
  input wire logic rxRecoveredClock,
  input wire logic rxPosIn,
  input wire logic rxNegIn,
  input wire logic txLineClock,
  input wire logic txPositiveRail,
  input wire logic txNegativeRail,
  input wire logic [7:0] wbAdr,
  input wire logic [31:0] wbDatI,
  input wire logic [3:0] wbSel,
  input wire logic wbWe,
  input wire logic wbCyc,
  input wire logic wbStb,
  output logic [31:0] wbDatO,
  output logic wbAck,
  output logic rxPositiveRail,
  output logic rxNegativeRail,
  output logic txPosSampled,
  output logic txNegSampled,
  output logic rxZeroSubstEnable,
  output logic txZeroSubstEnable,
  output logic lineIsT1,
  output logic jitterAttenEnable,
  output logic jitterAttenOnTx,
  output logic jitterClockFromPll,
  output logic eqGainLimit,
  output logic [2:0] waveshapeCode,
  output logic [1:0] loopbackCode,
  output logic [1:0] backplaneRate,
  output logic backplaneClockOut
);

  // ----------------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------------
  localparam int PHASE_W = `LHM_PHASE_W;
  localparam int SYNC_W = 19;

  // phase step per master clock for a backplane rate in kHz
  function automatic logic [PHASE_W-1:0] phaseStep(input int khz);
    longint full;
    full = (longint'(khz) << PHASE_W) / `LHM_MCLK_KHZ;
    return full[PHASE_W-1:0];
  endfunction

  localparam logic [PHASE_W-1:0] STEP_16M = phaseStep(`LHM_BP_KHZ_16M);
  localparam logic [PHASE_W-1:0] STEP_8M = phaseStep(`LHM_BP_KHZ_8M);
  localparam logic [PHASE_W-1:0] STEP_4M = phaseStep(`LHM_BP_KHZ_4M);
  localparam logic [PHASE_W-1:0] STEP_2M = phaseStep(`LHM_BP_KHZ_2M);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [SYNC_W-1:0] pinRaw;
  logic [SYNC_W-1:0] pinSync;
  logic hwRstS;
  logic edgeS;
  logic jaDisS;
  logic lineS;
  logic zsDisS;
  logic jaMuxS;
  logic jaPlaceS;
  logic eqS;
  logic [2:0] waveS;
  logic [1:0] loopS;
  logic rxClkS;
  logic rxPosS;
  logic rxNegS;
  logic txClkS;
  logic txPosS;
  logic txNegS;

  // straps and link pins come from outside the mclk domain
  assign pinRaw = {hw_reset_n, rxTxEdgeSelect, jitterAttenDisable,
                   lineStandardSelect, zeroSubstEnablePin,
                   jitterClockMuxSelect, jitterAttenPlacement,
                   equalizerGainLimit, txWaveshapeSelect, loopbackSelect,
                   rxRecoveredClock, rxPosIn, rxNegIn, txLineClock,
                   txPositiveRail, txNegativeRail};

  lhm_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .din(pinRaw),
    .dout(pinSync)
  ); // R17

  assign {hwRstS, edgeS, jaDisS, lineS, zsDisS, jaMuxS, jaPlaceS, eqS,
          waveS, loopS, rxClkS, rxPosS, rxNegS, txClkS, txPosS,
          txNegS} = pinSync;

  // ----------------------------------------------------------------------
  // state and edge events
  // ----------------------------------------------------------------------
  lhm_pkg::lhm_state_t cur_reg;
  lhm_pkg::lhm_state_t cur_next;
  logic rxRise;
  logic rxFall;
  logic txRise;
  logic txFall;
  logic wbReq;
  logic wrByte0;
  logic [PHASE_W-1:0] phaseStepSel;

  // edges of the synchronised line clocks, one mclk wide
  assign rxRise = rxClkS & ~cur_reg.rxClkPrev;
  assign rxFall = ~rxClkS & cur_reg.rxClkPrev;
  assign txRise = txClkS & ~cur_reg.txClkPrev;
  assign txFall = ~txClkS & cur_reg.txClkPrev;

  // a new request is taken only while no answer is standing
  assign wbReq = wbCyc & wbStb & ~cur_reg.ack;
  assign wrByte0 = wbReq & wbWe & wbSel[0];

  // phase step for the selected backplane rate
  always_comb begin
    case (cur_reg.bpRate)
      lhm_pkg::LHM_BP_16M: phaseStepSel = STEP_16M;
      lhm_pkg::LHM_BP_8M: phaseStepSel = STEP_8M;
      lhm_pkg::LHM_BP_4M: phaseStepSel = STEP_4M;
      lhm_pkg::LHM_BP_2M: phaseStepSel = STEP_2M;
      default: phaseStepSel = STEP_16M;
    endcase
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    cur_next = cur_reg;
    cur_next.rxClkPrev = rxClkS;
    cur_next.txClkPrev = txClkS;

    // rx rails launched on the edge chosen by the rx edge bit
    if (cur_reg.ccTwo[`LHM_CC2_RX_EDGE] ? rxFall : rxRise) begin
      cur_next.rxPos = rxPosS; // R1 R2
      cur_next.rxNeg = rxNegS;
    end
    // tx rails captured on the opposite sense of edge
    if (cur_reg.ccTwo[`LHM_CC2_TX_EDGE] ? txRise : txFall) begin
      cur_next.txPos = txPosS; // R1 R2
      cur_next.txNeg = txNegS;
    end

    // backplane phase restarts on each recovered clock rise so the
    // synthesised clock stays referenced to the line, not to mclk
    if (rxRise) begin
      cur_next.bpPhase = '0; // R12
    end else begin
      cur_next.bpPhase = cur_reg.bpPhase + phaseStepSel;
    end
    cur_next.backplane_clock_out = cur_reg.bpPhase[PHASE_W-1];

    // wishbone: answer exactly one cycle after the request appears
    cur_next.ack = wbReq;
    cur_next.rdData = '0;
    if (wbReq && !wbWe) begin
      case (wbAdr)
        `LHM_OFF_STATUS: cur_next.rdData = {13'h0000, pinSync};
        `LHM_OFF_MODE: cur_next.rdData = {31'h0000_0000, cur_reg.swMode};
        `LHM_OFF_CC_TWO: cur_next.rdData = {28'h000_0000, cur_reg.ccTwo};
        `LHM_OFF_CC_FIVE: begin
          cur_next.rdData[`LHM_CC5_RATE_HI:`LHM_CC5_RATE_LO] =
            cur_reg.bpRate;
        end
        default: cur_next.rdData = '0;
      endcase
    end

    // software writes count only in software mode, except the mode bit
    if (wrByte0 && wbAdr == `LHM_OFF_MODE) begin
      cur_next.swMode = wbDatI[`LHM_MODE_SW];
    end
    if (wrByte0 && cur_reg.swMode && wbAdr == `LHM_OFF_CC_TWO) begin
      cur_next.ccTwo = wbDatI[`LHM_CC2_W-1:0];
    end
    if (wrByte0 && cur_reg.swMode && wbAdr == `LHM_OFF_CC_FIVE) begin
      cur_next.bpRate = lhm_pkg::lhm_bp_rate_t'(
        wbDatI[`LHM_CC5_RATE_HI:`LHM_CC5_RATE_LO]); // R12
    end

    // hardware mode: straps own the control bits
    if (!cur_reg.swMode) begin
      cur_next.ccTwo[`LHM_CC2_RX_EDGE] = edgeS; // R3
      cur_next.ccTwo[`LHM_CC2_TX_EDGE] = edgeS; // R3
      cur_next.ccTwo[`LHM_CC2_RX_ZS] = ~zsDisS; // R6 R7
      cur_next.ccTwo[`LHM_CC2_TX_ZS] = ~zsDisS; // R6 R7
      cur_next.bpRate = lhm_pkg::LHM_BP_16M; // R13
    end

    // static line controls follow their straps
    cur_next.jaEnable = ~jaDisS; // R4
    cur_next.lineT1 = lineS; // R5
    cur_next.jaClkPll = jaMuxS; // R9 R10
    cur_next.jaPlaceTx = jaPlaceS; // R11
    cur_next.eqLimit = eqS; // R14
    cur_next.waveshape = waveS; // R15
    cur_next.loopback = loopS; // R16

    // held hardware reset wins over every strap and write
    if (!hwRstS) begin
      cur_next.ccTwo = `LHM_CC2_RST; // R8
      cur_next.bpRate = lhm_pkg::lhm_bp_rate_t'(`LHM_RATE_RST);
      cur_next.swMode = 1'b0;
      cur_next.jaEnable = 1'b0;
      cur_next.lineT1 = 1'b0;
      cur_next.jaClkPll = 1'b0;
      cur_next.jaPlaceTx = 1'b0;
      cur_next.eqLimit = 1'b0;
      cur_next.waveshape = '0;
      cur_next.loopback = '0;
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------------
  assign wbDatO = cur_reg.rdData;
  assign wbAck = cur_reg.ack;
  assign rxPositiveRail = cur_reg.rxPos;
  assign rxNegativeRail = cur_reg.rxNeg;
  assign txPosSampled = cur_reg.txPos;
  assign txNegSampled = cur_reg.txNeg;
  assign rxZeroSubstEnable = cur_reg.ccTwo[`LHM_CC2_RX_ZS];
  assign txZeroSubstEnable = cur_reg.ccTwo[`LHM_CC2_TX_ZS];
  assign lineIsT1 = cur_reg.lineT1;
  assign jitterAttenEnable = cur_reg.jaEnable;
  assign jitterAttenOnTx = cur_reg.jaPlaceTx;
  assign jitterClockFromPll = cur_reg.jaClkPll;
  assign eqGainLimit = cur_reg.eqLimit;
  assign waveshapeCode = cur_reg.waveshape;
  assign loopbackCode = cur_reg.loopback;
  assign backplaneRate = cur_reg.bpRate;
  assign backplaneClockOut = cur_reg.backplane_clock_out;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  property p_rx_rise_launch;
    (rxRise && !cur_reg.ccTwo[`LHM_CC2_RX_EDGE])
      |=> (rxPositiveRail == $past(rxPosS))
          && (rxNegativeRail == $past(rxNegS));
  endproperty
  a_rx_rise_launch: assert property (p_rx_rise_launch) // R1
    else $error("rx rails not launched on rising rx clock");

  property p_rx_fall_launch;
    (rxFall && cur_reg.ccTwo[`LHM_CC2_RX_EDGE])
      |=> rxPositiveRail == $past(rxPosS);
  endproperty
  a_rx_fall_launch: assert property (p_rx_fall_launch) // R2
    else $error("rx rails not launched on falling rx clock");

  property p_tx_fall_sample;
    (txFall && !cur_reg.ccTwo[`LHM_CC2_TX_EDGE])
      |=> txPosSampled == $past(txPosS);
  endproperty
  a_tx_fall_sample: assert property (p_tx_fall_sample) // R1
    else $error("tx rails not sampled on falling tx clock");

  property p_tx_hold;
    (!txRise && !txFall) |=> $stable(txPosSampled) && $stable(txNegSampled);
  endproperty
  a_tx_hold: assert property (p_tx_hold) // R2
    else $error("tx sample changed without a tx clock edge");

  property p_edge_pin;
    (!cur_reg.swMode && hwRstS) |=>
      cur_reg.ccTwo[1:0] == {2{$past(edgeS)}};
  endproperty
  a_edge_pin: assert property (p_edge_pin) // R3
    else $error("edge select bits do not follow the strap");

  property p_zs_pin;
    (!cur_reg.swMode && hwRstS) |=>
      (rxZeroSubstEnable == !$past(zsDisS))
      && (txZeroSubstEnable == !$past(zsDisS));
  endproperty
  a_zs_pin: assert property (p_zs_pin) // R7
    else $error("coding enables do not follow the strap");

  property p_hw_reset;
    !hwRstS |=> (cur_reg.ccTwo == 4'h0) && !cur_reg.swMode
      && (backplaneRate == 2'h0) && !jitterAttenEnable;
  endproperty
  a_hw_reset: assert property (p_hw_reset) // R8
    else $error("control bits not cleared by hardware reset");

  property p_ja_enable;
    hwRstS |=> jitterAttenEnable == !$past(jaDisS);
  endproperty
  a_ja_enable: assert property (p_ja_enable) // R4
    else $error("attenuator enable wrong for strap");

  property p_line_std;
    hwRstS |=> lineIsT1 == $past(lineS);
  endproperty
  a_line_std: assert property (p_line_std) // R5
    else $error("line standard does not follow strap");

  property p_hw_rate;
    (!cur_reg.swMode && hwRstS) |=> backplaneRate == 2'h0;
  endproperty
  a_hw_rate: assert property (p_hw_rate) // R13
    else $error("hardware mode not at fastest backplane rate");

  property p_bp_ref;
    rxRise |=> cur_reg.bpPhase == '0 ##1 backplaneClockOut == 1'b0;
  endproperty
  a_bp_ref: assert property (p_bp_ref) // R12
    else $error("backplane phase not restarted by rx clock");

  property p_wb_ack;
    (wbCyc && wbStb && !wbAck) |=> wbAck ##1 !wbAck;
  endproperty
  a_wb_ack: assert property (p_wb_ack)
    else $error("wishbone ack not a single cycle after request");

endmodule

// ==== rtl/lhm_sync.sv ====
// two-flop synchroniser for a vector of asynchronous pins, straps and line clocks and rails alike
`timescale 1ns/1ps

module lhm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  // ----------------------------------------------------------------------
  // one independent two-stage chain per bit
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_reg;
      logic stable_reg;
      // first stage feeds only the second stage
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          meta_reg <= 1'b0;
          stable_reg <= 1'b0;
        end else begin
          meta_reg <= din[i];
          stable_reg <= meta_reg;
        end
      end
      assign dout[i] = stable_reg;
    end
  endgenerate

endmodule

// ==== sim/lhm_line_model.sv ====
// far-side model: recovered rx clock and data, framer tx clock and rails
`timescale 1ns/1ps

module lhm_line_model (
  input wire logic mclk,
  input wire logic arst_n,
  output logic rxClk,
  output logic rxPos,
  output logic rxNeg,
  output logic txClk,
  output logic txPos,
  output logic txNeg
);
  // ----------------------------------------------------------------------
  // line clock of 16 mclk cycles, data moves a quarter period off each edge
  // ----------------------------------------------------------------------
  logic [3:0] phaseReg;
  logic [1:0] dataReg;

  // data changes away from both edges, so rise and fall see other values
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      phaseReg <= 4'h0;
      dataReg <= 2'h0;
    end else begin
      phaseReg <= phaseReg + 4'h1;
      if (phaseReg[2:0] == 3'h3) begin
        dataReg <= dataReg + 2'h1;
      end
    end
  end

  // tx rails differ from rx rails so a crossed wire shows up
  assign rxClk = ~phaseReg[3];
  assign txClk = ~phaseReg[3];
  assign rxPos = dataReg[0];
  assign rxNeg = dataReg[1];
  assign txPos = ~dataReg[0];
  assign txNeg = dataReg[1] ^ dataReg[0];
endmodule

// ==== sim/testbench.sv ====
// self-checking bench for the lhm pin decode block
`timescale 1ns/1ps
`include "lhm_defines.svh"

module testbench;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic hwResetN = 1'b1;
  logic [11:0] straps = 12'h000;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDatI = 32'h0000_0000;
  logic [3:0] wbSel = 4'h0;
  logic wbWe = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic [31:0] wbDatO;
  logic wbAck, rxClk, txClk, backplane_clock_out;
  logic [1:0] pinRx, pinTx, rxRail, txSamp, backplaneRate;
  logic [1:0] rxZs, txZs;
  logic [11:0] outVec;
  int n_fail = 0;
  int checks_done = 0;
  // rows: strap inputs, expected control outputs, expected coding/edge bits
  logic [27:0] rows [4] = '{28'hfff_2ff3, 28'h155_1950, 28'haaa_f6af,
    28'h000_d00c};

  // free-running master clock
  always #12.5 mclk = ~mclk;

  // ----------------------------------------------------------------------
  // design and far side
  // ----------------------------------------------------------------------
  lhm_pin_decode dut (.mclk(mclk), .arst_n(arst_n), .hw_reset_n(hwResetN),
    .rxTxEdgeSelect(straps[11]), .jitterAttenDisable(straps[10]),
    .lineStandardSelect(straps[9]), .zeroSubstEnablePin(straps[8]),
    .jitterClockMuxSelect(straps[7]), .jitterAttenPlacement(straps[6]),
    .equalizerGainLimit(straps[5]), .txWaveshapeSelect(straps[4:2]),
    .loopbackSelect(straps[1:0]), .rxRecoveredClock(rxClk),
    .rxPosIn(pinRx[1]), .rxNegIn(pinRx[0]), .txLineClock(txClk),
    .txPositiveRail(pinTx[1]), .txNegativeRail(pinTx[0]), .wbAdr(wbAdr),
    .wbDatI(wbDatI), .wbSel(wbSel), .wbWe(wbWe), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbDatO(wbDatO), .wbAck(wbAck),
    .rxPositiveRail(rxRail[1]), .rxNegativeRail(rxRail[0]),
    .txPosSampled(txSamp[1]), .txNegSampled(txSamp[0]),
    .rxZeroSubstEnable(outVec[11]), .txZeroSubstEnable(outVec[10]),
    .lineIsT1(outVec[9]), .jitterAttenEnable(outVec[8]),
    .jitterAttenOnTx(outVec[7]), .jitterClockFromPll(outVec[6]),
    .eqGainLimit(outVec[5]), .waveshapeCode(outVec[4:2]),
    .loopbackCode(outVec[1:0]), .backplaneRate(backplaneRate),
    .backplaneClockOut(backplane_clock_out));

  lhm_line_model far (.mclk(mclk), .arst_n(arst_n), .rxClk(rxClk),
    .rxPos(pinRx[1]), .rxNeg(pinRx[0]), .txClk(txClk), .txPos(pinTx[1]),
    .txNeg(pinTx[0]));

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic ran_out;
    n_fail++;
    $display("Error at %0t: wait ran out", $time);
    wrap_up();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("Error at %0t: count %0d out of range", $time, got);
    end
  endtask

  // classic single cycle: raised just after a rising edge, held until the
  // rising edge that samples ack high; data taken and request dropped there
  task automatic wb_xfer(input logic we, input logic [7:0] adr,
    input logic [31:0] dat, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge mclk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= dat;
    wbSel <= 4'hf;
    do begin
      @(posedge mclk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    if (n >= 20) ran_out();
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  // waits for a rise or fall of the rx or tx line clock pin
  task automatic wait_pin(input logic wantRise, input logic tx);
    logic p, q;
    int n;
    n = 0;
    q = tx ? txClk : rxClk;
    do begin
      @(negedge mclk);
      p = q;
      q = tx ? txClk : rxClk;
      n++;
    end while (!(q === wantRise && p === ~wantRise) && n < 40);
    if (n >= 40) ran_out();
  endtask

  task automatic count_bp(output int c);
    logic p;
    c = 0;
    p = backplane_clock_out;
    repeat (400) begin
      @(negedge mclk);
      if (backplane_clock_out === 1'b1 && p === 1'b0) c++;
      p = backplane_clock_out;
    end
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    int i;
    int c;
    logic [31:0] rd;
    logic [11:0] prevOut;
    logic [1:0] cap;
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (6) @(negedge mclk);
    chk(outVec, 12'hd00);
    chk(backplaneRate, 2'h0);
    prevOut = 12'hd00;
    // strap table: old value still out after two edges, new one after four
    for (i = 0; i < 4; i++) begin
      @(posedge mclk);
      straps <= rows[i][27:16];
      repeat (2) @(negedge mclk);
      chk(outVec, prevOut);
      repeat (2) @(negedge mclk);
      chk(outVec, rows[i][15:4]);
      wb_xfer(1'b0, `LHM_OFF_CC_TWO, 32'h0000_0000, rd);
      chk(rd, rows[i][3:0]);
      prevOut = rows[i][15:4];
    end
    // rail timing under both edge selections
    for (i = 0; i < 2; i++) begin
      @(posedge mclk);
      straps[11] <= i[0];
      repeat (6) @(negedge mclk);
      repeat (3) begin
        wait_pin(~i[0], 1'b0);
        cap = pinRx;
        repeat (13) @(negedge mclk);
        chk(rxRail, cap);
        wait_pin(i[0], 1'b1);
        cap = pinTx;
        repeat (13) @(negedge mclk);
        chk(txSamp, cap);
      end
    end
    // backplane rate: fixed in hardware mode, programmable in software mode
    count_bp(c);
    chk_rng(c, 130, 200);
    wb_xfer(1'b1, `LHM_OFF_CC_FIVE, 32'h0000_0040, rd);
    @(negedge mclk);
    chk(backplaneRate, 2'h0);
    wb_xfer(1'b1, `LHM_OFF_MODE, 32'h0000_0001, rd);
    wb_xfer(1'b1, `LHM_OFF_CC_FIVE, 32'h0000_0040, rd);
    wb_xfer(1'b0, `LHM_OFF_CC_FIVE, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0040);
    @(negedge mclk);
    chk(backplaneRate, 2'h1);
    count_bp(c);
    chk_rng(c, 60, 100);
    wb_xfer(1'b0, 8'h20, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    // the two slower rate codes, never reached by the counts above
    wb_xfer(1'b1, `LHM_OFF_CC_FIVE, 32'h0000_00c0, rd);
    wb_xfer(1'b0, `LHM_OFF_CC_FIVE, 32'h0000_0000, rd);
    chk(rd, 32'h0000_00c0);
    chk(backplaneRate, 2'h3);
    wb_xfer(1'b1, `LHM_OFF_CC_FIVE, 32'h0000_0080, rd);
    wb_xfer(1'b0, `LHM_OFF_CC_FIVE, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0080);
    chk(backplaneRate, 2'h2);
    // hardware reset pin clears mode, rate and every control output
    @(posedge mclk);
    straps <= 12'h000;
    hwResetN <= 1'b0;
    repeat (4) @(negedge mclk);
    chk(outVec, 12'h000);
    chk(backplaneRate, 2'h0);
    wb_xfer(1'b0, `LHM_OFF_MODE, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    wb_xfer(1'b0, `LHM_OFF_CC_TWO, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    @(posedge mclk);
    hwResetN <= 1'b1;
    repeat (5) @(negedge mclk);
    chk(outVec, 12'hd00);
    wrap_up();
  end
endmodule
